// ===== core/pcl_consts.svh
// Purpose: numeric constants of the configuration, message and lock translator
// Assumes: included by bare name from the package only; the design modules use its macros
// Notes: definitions only
`ifndef PCL_CONSTS_SVH
`define PCL_CONSTS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PCL_CLK_MHZ 10
// pme resend interval in microseconds (not fixed by the bridge behaviour)
`define PCL_PME_RESEND_US 1000
`define PCL_PME_RESEND_CYC (`PCL_PME_RESEND_US * `PCL_CLK_MHZ)

// ----------------------------------------------------------------------------
// configuration address layout
// ----------------------------------------------------------------------------
`define PCL_IDSEL_LSB 16
`define PCL_BUS_LSB 16
`define PCL_DEV_LSB 11
`define PCL_FUNC_LSB 8
`define PCL_REG_LSB 2
`define PCL_CFG0_LOW 2'h0
`define PCL_CFG1_LOW 2'h1

// ----------------------------------------------------------------------------
// message fields and control bit location
// ----------------------------------------------------------------------------
`define PCL_PME_DEV 5'h00
`define PCL_PME_FUNC 3'h0
`define PCL_PME_TAG 8'h00
`define PCL_GEN_CTRL_OFS 8'hd4
`define PCL_LOCK_EN_BIT 12
`define PCL_SYNC_W 8

`endif

// ===== core/pcl_pkg.sv
// Purpose: shared types of the configuration, message and lock translator
// Assumes: pcl_consts.svh holds all numbers
// Notes: enumerations only
`include "pcl_consts.svh"

package pcl_pkg;
   // downstream request kinds from the express core
   typedef enum logic [2:0] {
      REQ_CFG0 = 3'h0,
      REQ_CFG1 = 3'h1,
      REQ_MEMRD = 3'h2,
      REQ_MEMRDLK = 3'h3,
      REQ_MEMWR = 3'h4,
      REQ_UNLOCK = 3'h5
   } pcl_req_t;
   // secondary bus command kinds
   typedef enum logic [1:0] {
      PCI_CFG0 = 2'h0,
      PCI_CFG1 = 2'h1,
      PCI_MEMRD = 2'h2,
      PCI_MEMWR = 2'h3
   } pcl_pci_t;
   // upstream message kinds
   typedef enum logic [1:0] {
      MSG_ASSERT_INTX = 2'h0,
      MSG_DEASSERT_INTX = 2'h1,
      MSG_PME = 2'h2
   } pcl_msg_t;
   // completion status
   typedef enum logic {
      CPL_SC = 1'h0,
      CPL_UR = 1'h1
   } pcl_cpl_t;
   // request sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ARB = 3'h1,
      ST_BACKOFF = 3'h2,
      ST_ISSUE = 3'h3,
      ST_WAIT = 3'h4
   } pcl_state_t;
endpackage : pcl_pkg

// ===== core/pcl_pme_gen.sv
// Purpose: turn the secondary pme pin into upstream pme message requests
// Assumes: pme pin is asynchronous to clock; sent pulses when a message leaves
// Notes: a new request fires on the falling edge and again every interval
`timescale 1ns/1ps
`default_nettype none

module pcl_pme_gen
   import pcl_pkg::*;
#(
   parameter int unsigned RESEND_CYC = `PCL_PME_RESEND_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // pin and handshake
   input wire logic pmeInN,
   input wire logic sent,
   output logic pending
);
   // ---------------------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------------------
   logic syncA_q; // first stage, read only by the second
   logic syncB_q;
   logic syncC_q;
   logic level_q; // accepted pin level
   logic [31:0] timer_q; // resend interval counter
   logic fire; // new message wanted this cycle

   // three flops; level changes once the last two agree
   always_ff @(posedge clock) begin
      if (srst) begin
         syncA_q <= 1'b1;
         syncB_q <= 1'b1;
         syncC_q <= 1'b1;
         level_q <= 1'b1;
      end else begin
         syncA_q <= pmeInN;
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         if (syncB_q == syncC_q) begin
            level_q <= syncC_q;
         end
      end
   end

   // falling edge or interval expiry while still low
   assign fire = (!syncC_q && (syncB_q == syncC_q) && level_q) ||
                 (!level_q && (timer_q == RESEND_CYC - 1));

   // ---------------------------------------------------------------------------
   // resend interval
   // ---------------------------------------------------------------------------
   // count only while the pin stays low; clear once it returns high
   always_ff @(posedge clock) begin
      if (srst || level_q || fire) begin
         timer_q <= 32'h0;
      end else begin
         timer_q <= timer_q + 32'h1;
      end
   end

   // pending request; a new fire beats the send of the older one
   always_ff @(posedge clock) begin
      if (srst) begin
         pending <= 1'b0;
      end else begin
         pending <= (pending && !sent) || fire;
      end
   end
endmodule : pcl_pme_gen

`default_nettype wire

// ===== core/pcl_xlat_top.sv
// Purpose: translate downstream config and memory requests onto the secondary
//    bus, run the bus lock protocol and raise intx and pme messages upstream
// Assumes: one request outstanding at a time; a bus engine on the same clock
//    runs the actual bus cycles and reports address phase and completion
// Notes: lock and arbitration pins are active low and resynchronised
`timescale 1ns/1ps
`default_nettype none

module pcl_xlat_top
   import pcl_pkg::*;
#(
   parameter int unsigned PME_RESEND_CYC = `PCL_PME_RESEND_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // static configuration
   input wire logic [7:0] secBusNum,
   input wire logic lockEnable,
   // downstream request from the express core
   input wire logic reqValid,
   input wire pcl_req_t reqKind,
   input wire logic [7:0] reqBus,
   input wire logic [4:0] reqDev,
   input wire logic [2:0] reqFunc,
   input wire logic [5:0] reqReg,
   input wire logic [31:0] reqAddr,
   output logic reqReady,
   // local configuration space hand-off
   output logic cfgLocalValid,
   // secondary bus engine
   output logic pciCmdValid,
   output pcl_pci_t pciCmdKind,
   output logic [31:0] pciCmdAddr,
   output logic pciCmdLocked,
   input wire logic pciCmdReady,
   input wire logic pciAddrPhase,
   input wire logic pciDone,
   // completion back upstream
   output logic cplValid,
   output pcl_cpl_t cplStatus,
   output logic cplLocked,
   // upstream messages
   output logic msgValid,
   output pcl_msg_t msgKind,
   output logic [1:0] msgIntx,
   output logic [15:0] msgReqId,
   output logic [7:0] msgTag,
   input wire logic msgReady,
   // secondary bus pins
   input wire logic gntInN,
   input wire logic lockInN,
   input wire logic frameInN,
   input wire logic irdyInN,
   input wire logic [3:0] intInN,
   input wire logic pmeInN,
   output logic reqOutN,
   output logic lockOutN,
   output logic lockOeN
);
   // ---------------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------------
   // type 0 address: idsel on the top half, function and register below
   function automatic logic [31:0] cfg0Addr(input logic [4:0] dev,
         input logic [2:0] fn, input logic [5:0] rg);
      logic [31:0] a;
      a = 32'h0;
      if (!dev[4]) begin
         a[`PCL_IDSEL_LSB + dev[3:0]] = 1'b1;
      end
      a[`PCL_FUNC_LSB +: 3] = fn;
      a[`PCL_REG_LSB +: 6] = rg;
      a[1:0] = `PCL_CFG0_LOW;
      return a;
   endfunction

   // type 1 address: bus, device, function, register, low bits 01
   function automatic logic [31:0] cfg1Addr(input logic [7:0] bus,
         input logic [4:0] dev, input logic [2:0] fn, input logic [5:0] rg);
      logic [31:0] a;
      a = 32'h0;
      a[`PCL_BUS_LSB +: 8] = bus;
      a[`PCL_DEV_LSB +: 5] = dev;
      a[`PCL_FUNC_LSB +: 3] = fn;
      a[`PCL_REG_LSB +: 6] = rg;
      a[1:0] = `PCL_CFG1_LOW;
      return a;
   endfunction

   // ---------------------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------------------
   logic [7:0] syncA_q; // first stage, read only by the second
   logic [7:0] syncB_q;
   logic [7:0] syncC_q;
   logic [7:0] pins_q; // accepted levels {irdy, frame, lock, gnt, intd..inta}
   logic gntLow; // grant seen
   logic lockHigh; // lock free on the bus
   logic busIdle; // no frame, no irdy

   // three flops per pin; a bit changes once the last two agree
   always_ff @(posedge clock) begin
      if (srst) begin
         syncA_q <= 8'hff;
         syncB_q <= 8'hff;
         syncC_q <= 8'hff;
         pins_q <= 8'hff;
      end else begin
         syncA_q <= {irdyInN, frameInN, lockInN, gntInN, intInN};
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         pins_q <= (syncB_q & syncC_q) | (pins_q & (syncB_q ^ syncC_q));
      end
   end

   assign gntLow = !pins_q[4];
   assign lockHigh = pins_q[5];
   assign busIdle = pins_q[6] && pins_q[7];

   // ---------------------------------------------------------------------------
   // request sequencer and lock state
   // ---------------------------------------------------------------------------
   pcl_state_t state_q; // sequencer state
   logic lockedQ; // bridge in locked sequence
   logic lockOwn_q; // bridge owns the lock pin
   logic unlockPend_q; // unlock message waiting for drain
   logic curLocked_q; // current bus cycle belongs to the lock
   logic curRdLk_q; // current cycle is a locked read
   logic curNeedCpl_q; // current cycle answers upstream
   logic take; // request accepted this cycle
   logic blocked; // request held off by the lock

   // only forwarded config requests (REQ_CFG1) wait while locked; all other kinds are taken
   assign blocked = lockedQ && (reqKind == REQ_CFG1);
   assign take = reqValid && (state_q == ST_IDLE) && !blocked && !unlockPend_q;

   // ready only while idle and not held off
   always_ff @(posedge clock) begin
      if (srst) begin
         reqReady <= 1'b0;
      end else begin
         reqReady <= 1'b0;
         if (state_q == ST_IDLE && !take && !unlockPend_q) begin
            reqReady <= !blocked || !reqValid;
         end
      end
   end

   // main sequencer: decode, arbitrate for lock, issue, wait
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= ST_IDLE;
         pciCmdValid <= 1'b0;
         pciCmdKind <= PCI_CFG0;
         pciCmdAddr <= 32'h0;
         pciCmdLocked <= 1'b0;
         curLocked_q <= 1'b0;
         curRdLk_q <= 1'b0;
         curNeedCpl_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  curRdLk_q <= 1'b0;
                  curLocked_q <= 1'b0;
                  curNeedCpl_q <= 1'b1;
                  pciCmdAddr <= reqAddr;
                  case (reqKind)
                     REQ_CFG1: begin
                        pciCmdValid <= 1'b1;
                        state_q <= ST_ISSUE;
                        if (reqBus == secBusNum) begin
                           pciCmdKind <= PCI_CFG0;
                           pciCmdAddr <= cfg0Addr(reqDev, reqFunc, reqReg);
                        end else begin
                           pciCmdKind <= PCI_CFG1;
                           pciCmdAddr <= cfg1Addr(reqBus, reqDev, reqFunc, reqReg);
                        end
                     end
                     REQ_MEMRD: begin
                        // plain read while locked is answered UR instead
                        if (!lockedQ) begin
                           pciCmdValid <= 1'b1;
                           pciCmdKind <= PCI_MEMRD;
                           state_q <= ST_ISSUE;
                        end
                     end
                     REQ_MEMRDLK: begin
                        pciCmdKind <= PCI_MEMRD;
                        curRdLk_q <= 1'b1;
                        curLocked_q <= lockEnable;
                        if (lockEnable && !lockedQ) begin
                           state_q <= ST_ARB;
                        end else begin
                           pciCmdValid <= 1'b1;
                           state_q <= ST_ISSUE;
                        end
                     end
                     REQ_MEMWR: begin
                        pciCmdValid <= 1'b1;
                        pciCmdKind <= PCI_MEMWR;
                        curLocked_q <= lockedQ;
                        curNeedCpl_q <= 1'b0;
                        state_q <= ST_ISSUE;
                     end
                     default: begin
                        // type 0 config and unlock finish here
                        state_q <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_ARB: begin
               // lock free at grant: go; lock busy: withdraw
               if (gntLow && lockHigh) begin
                  pciCmdValid <= 1'b1;
                  state_q <= ST_ISSUE;
               end else if (gntLow) begin
                  state_q <= ST_BACKOFF;
               end
            end
            ST_BACKOFF: begin
               // re-arbitrate only with lock free and bus idle
               if (lockHigh && busIdle) begin
                  state_q <= ST_ARB;
               end
            end
            ST_ISSUE: begin
               // hold the command until the bus engine takes it
               if (pciCmdReady) begin
                  pciCmdValid <= 1'b0;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (pciDone) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
         pciCmdLocked <= (state_q == ST_IDLE) ? 1'b0 : curLocked_q;
      end
   end

   // bus request pin: low only while arbitrating for the lock
   always_ff @(posedge clock) begin
      if (srst) begin
         reqOutN <= 1'b1;
      end else begin
         reqOutN <= !(state_q == ST_ARB && !(gntLow && !lockHigh));
      end
   end

   // locked flag: set by locked read data, cleared by a drained unlock
   always_ff @(posedge clock) begin
      if (srst) begin
         lockedQ <= 1'b0;
         unlockPend_q <= 1'b0;
      end else begin
         if (state_q == ST_WAIT && pciDone && curRdLk_q && curLocked_q) begin
            lockedQ <= 1'b1;
         end else if (unlockPend_q && state_q == ST_IDLE) begin
            lockedQ <= 1'b0;
         end
         if (take && reqKind == REQ_UNLOCK) begin
            unlockPend_q <= 1'b1;
         end else if (state_q == ST_IDLE) begin
            unlockPend_q <= 1'b0;
         end
      end
   end

   // lock pin ownership taken after the first locked address phase
   always_ff @(posedge clock) begin
      if (srst) begin
         lockOwn_q <= 1'b0;
      end else if (unlockPend_q && state_q == ST_IDLE) begin
         lockOwn_q <= 1'b0;
      end else if (state_q == ST_WAIT && pciAddrPhase && curLocked_q) begin
         lockOwn_q <= 1'b1;
      end
   end

   // lock pin: driven while owned and enabled, high in locked address phases
   always_ff @(posedge clock) begin
      if (srst) begin
         lockOutN <= 1'b1;
         lockOeN <= 1'b1;
      end else begin
         lockOeN <= !(lockOwn_q && lockEnable);
         lockOutN <= !(lockOwn_q && lockEnable &&
                       !(pciAddrPhase && curLocked_q));
      end
   end

   // ---------------------------------------------------------------------------
   // completions and local config hand-off
   // ---------------------------------------------------------------------------
   // one-cycle completion for non-posted cycles and for refused reads
   always_ff @(posedge clock) begin
      if (srst) begin
         cplValid <= 1'b0;
         cplStatus <= CPL_SC;
         cplLocked <= 1'b0;
         cfgLocalValid <= 1'b0;
      end else begin
         cplValid <= 1'b0;
         cplStatus <= CPL_SC;
         cplLocked <= 1'b0;
         cfgLocalValid <= take && (reqKind == REQ_CFG0);
         if (take && reqKind == REQ_MEMRD && lockedQ) begin
            cplValid <= 1'b1;
            cplStatus <= CPL_UR;
         end else if (state_q == ST_WAIT && pciDone && curNeedCpl_q) begin
            cplValid <= 1'b1;
            cplLocked <= curRdLk_q;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // upstream messages: intx changes and pme
   // ---------------------------------------------------------------------------
   logic [3:0] intSent_q; // last reported level per line, 1 = asserted
   logic [3:0] intDiff; // lines whose level changed
   logic [1:0] intPick; // lowest changed line
   logic pmePending; // pme message wanted
   logic pmeSent; // pme message leaving now

   assign intDiff = (~pins_q[3:0]) ^ intSent_q;
   assign intPick = intDiff[0] ? 2'h0 : intDiff[1] ? 2'h1 : intDiff[2] ? 2'h2 : 2'h3;
   assign pmeSent = msgValid && msgReady && (msgKind == MSG_PME);

   // resend timer and edge detect for the pme pin
   pcl_pme_gen #(
      .RESEND_CYC(PME_RESEND_CYC)
   ) pmeGen (
      .clock(clock),
      .srst(srst),
      .pmeInN(pmeInN),
      .sent(pmeSent),
      .pending(pmePending)
   );

   // message slot: held until taken; pme first, then intx changes
   always_ff @(posedge clock) begin
      if (srst) begin
         msgValid <= 1'b0;
         msgKind <= MSG_PME;
         msgIntx <= 2'h0;
         msgReqId <= 16'h0;
         msgTag <= 8'h0;
         intSent_q <= 4'h0;
      end else if (!msgValid || msgReady) begin
         msgValid <= 1'b0;
         if (pmePending && !pmeSent) begin
            msgValid <= 1'b1;
            msgKind <= MSG_PME;
            msgReqId <= {secBusNum, `PCL_PME_DEV, `PCL_PME_FUNC};
            msgTag <= `PCL_PME_TAG;
         end else if (intDiff != 4'h0) begin
            msgValid <= 1'b1;
            msgIntx <= intPick;
            msgReqId <= {secBusNum, `PCL_PME_DEV, `PCL_PME_FUNC};
            msgTag <= `PCL_PME_TAG;
            if (!pins_q[intPick]) begin
               msgKind <= MSG_ASSERT_INTX;
               intSent_q[intPick] <= 1'b1;
            end else begin
               msgKind <= MSG_DEASSERT_INTX;
               intSent_q[intPick] <= 1'b0;
            end
         end
      end
   end
endmodule : pcl_xlat_top

`default_nettype wire

// ===== verif/pcl_xlat_chk.sv
// Purpose: port-level assertions of the lock translator
// Assumes: sees only top-level ports
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pcl_xlat_chk import pcl_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // request side
   input wire logic [7:0] secBusNum,
   input wire logic lockEnable,
   input wire logic reqValid,
   input wire pcl_req_t reqKind,
   input wire logic cfgLocalValid,
   // bus engine
   input wire logic pciCmdValid,
   input wire pcl_pci_t pciCmdKind,
   input wire logic [31:0] pciCmdAddr,
   input wire logic pciCmdReady,
   input wire logic pciAddrPhase,
   // messages
   input wire logic msgValid,
   input wire pcl_msg_t msgKind,
   input wire logic [15:0] msgReqId,
   input wire logic [7:0] msgTag,
   // pins
   input wire logic gntInN,
   input wire logic lockInN,
   input wire logic reqOutN,
   input wire logic lockOutN,
   input wire logic lockOeN
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // locked read seen while the bridge is not driving lock
   sequence s_lkReq; reqValid && reqKind == REQ_MEMRDLK && lockEnable && lockOeN; endsequence
   // grant comes while someone else holds lock
   sequence s_busyGnt; !reqOutN && !gntInN && !lockInN && lockOeN; endsequence
   property p_rstRel; $fell(srst) |-> lockOeN && lockOutN && reqOutN; endproperty
   a_rstRel: assert property (p_rstRel) else $error("pins not released by reset");
   property p_lockEn; !lockEnable |-> lockOeN; endproperty
   a_lockEn: assert property (p_lockEn) else $error("lock driven while disabled");
   property p_lkReq; s_lkReq |-> ##[1:4] !reqOutN; endproperty
   a_lkReq: assert property (p_lkReq) else $error("no bus request for locked read");
   property p_busy; s_busyGnt |-> ##[1:8] reqOutN; endproperty
   a_busy: assert property (p_busy) else $error("request kept while lock busy");
   property p_own; $fell(lockOeN) |-> !lockOutN && ($past(pciAddrPhase) || $past(pciAddrPhase, 2));
   endproperty
   a_own: assert property (p_own) else $error("lock taken outside address phase");
   property p_idsel; pciCmdValid && pciCmdKind == PCI_CFG0
      |-> $onehot0(pciCmdAddr[31:16]) && pciCmdAddr[1:0] == 2'h0; endproperty
   a_idsel: assert property (p_idsel) else $error("bad type 0 address");
   property p_cfg1; pciCmdValid && pciCmdKind == PCI_CFG1
      |-> pciCmdAddr[1:0] == 2'h1 && pciCmdAddr[31:24] == 8'h00; endproperty
   a_cfg1: assert property (p_cfg1) else $error("bad type 1 address");
   property p_local; cfgLocalValid |-> !pciCmdValid; endproperty
   a_local: assert property (p_local) else $error("type 0 forwarded");
   property p_pmeId; msgValid && msgKind == MSG_PME |-> msgReqId == {secBusNum, 8'h00} && msgTag == 8'h00;
   endproperty
   a_pmeId: assert property (p_pmeId) else $error("bad pme id or tag");
   property p_hold; pciCmdValid && !pciCmdReady |=> pciCmdValid && $stable(pciCmdAddr); endproperty
   a_hold: assert property (p_hold) else $error("command dropped before taken");
endmodule // pcl_xlat_chk
`default_nettype wire

// ===== verif/pcl_bus_model.sv
// Purpose: secondary bus engine and pin model
// Assumes: lock line has a pull-up
// Notes: grant follows request one cycle later
`timescale 1ns/1ps
`default_nettype none
module pcl_bus_model #(parameter int DLY = 2) (
   // clock
   input wire logic clock,
   // command side
   input wire logic pciCmdValid,
   output logic pciCmdReady,
   output logic pciAddrPhase,
   output logic pciDone,
   // pins
   input wire logic reqOutN,
   input wire logic lockOutN,
   input wire logic lockOeN,
   input wire logic holdLock,
   output logic gntInN,
   output logic lockInN,
   output logic frameInN,
   output logic irdyInN
);
   int cnt = 0; // cycles left in the running transfer
   logic busy = 1'b0;
   initial begin
      pciCmdReady = 1'b0;
      pciAddrPhase = 1'b0;
      pciDone = 1'b0;
      gntInN = 1'b1;
   end
   // wired lock level: pull-up when released, another master may hold it
   assign lockInN = (lockOeN ? 1'b1 : lockOutN) & !holdLock;
   assign frameInN = !busy;
   assign irdyInN = !busy;
   // accept, address phase, then completion DLY+1 cycles after the address phase
   always @(posedge clock) begin
      gntInN <= reqOutN;
      pciCmdReady <= pciCmdValid && !pciCmdReady && !busy;
      pciAddrPhase <= pciCmdReady;
      pciDone <= busy && cnt == 1;
      if (pciCmdReady) begin
         busy <= 1'b1;
         cnt <= DLY + 1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (cnt == 1) begin
         busy <= 1'b0;
      end
   end
endmodule // pcl_bus_model
`default_nettype wire

// ===== verif/tb_pcie_to_pci_config_lock_translator.sv
// Purpose: self-checking bench of the lock translator
// Assumes: bus model answers commands
// Notes: short pme resend interval
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_to_pci_config_lock_translator import pcl_pkg::*;;
   typedef struct {pcl_req_t k; logic [7:0] b; logic [4:0] d; logic [2:0] f;
      logic [5:0] r; logic loc; pcl_pci_t ek; logic [31:0] ea;} pcl_row_t;
   logic clock = 1'b0, srst = 1'b1, lockEnable = 1'b0, reqValid = 1'b0;
   logic msgReady = 1'b1, pmeInN = 1'b1, holdLock = 1'b0;
   logic [7:0] secBusNum = 8'h05, reqBus = 8'h00;
   logic [4:0] reqDev = 5'h00;
   logic [2:0] reqFunc = 3'h0;
   logic [5:0] reqReg = 6'h00;
   logic [31:0] reqAddr = 32'h0;
   logic [3:0] intInN = 4'hf;
   pcl_req_t reqKind = REQ_CFG0;
   wire logic reqReady, cfgLocalValid, pciCmdValid, pciCmdLocked, pciCmdReady, pciAddrPhase;
   wire logic pciDone, cplValid, cplLocked, msgValid, gntInN, lockInN, frameInN, irdyInN;
   wire logic reqOutN, lockOutN, lockOeN;
   wire logic [31:0] pciCmdAddr;
   wire logic [1:0] msgIntx;
   wire logic [15:0] msgReqId;
   wire logic [7:0] msgTag;
   pcl_pci_t pciCmdKind;
   pcl_cpl_t cplStatus;
   pcl_msg_t msgKind;
   int errors = 0, checked = 0, n, cnt;
   // ordinary requests and the bus command or local hand-off each must give
   pcl_row_t rows [7] = '{
      '{REQ_CFG0, 8'h05, 5'h00, 3'h0, 6'h00, 1'b1, PCI_CFG0, 32'h0},
      '{REQ_CFG1, 8'h05, 5'h00, 3'h3, 6'h0a, 1'b0, PCI_CFG0, 32'h00010328},
      '{REQ_CFG1, 8'h05, 5'h0f, 3'h0, 6'h00, 1'b0, PCI_CFG0, 32'h80000000},
      '{REQ_CFG1, 8'h05, 5'h10, 3'h1, 6'h01, 1'b0, PCI_CFG0, 32'h00000104},
      '{REQ_CFG1, 8'h06, 5'h1f, 3'h7, 6'h3f, 1'b0, PCI_CFG1, 32'h0006fffd},
      '{REQ_MEMWR, 8'h00, 5'h00, 3'h0, 6'h00, 1'b0, PCI_MEMWR, 32'h12345678},
      '{REQ_MEMRD, 8'h00, 5'h00, 3'h0, 6'h00, 1'b0, PCI_MEMRD, 32'h0000a000}};
   pcl_xlat_top #(.PME_RESEND_CYC(20)) dut (.*);
   pcl_bus_model bus (.*);
   initial begin
      forever #50 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   // one-cycle request, taken while the sequencer is idle
   task automatic send(input pcl_req_t k, input logic [31:0] a);
      reqKind = k;
      reqAddr = a;
      reqValid = 1'b1;
      idle(1);
      reqValid = 1'b0;
   endtask
   // bounded wait: 0 command or local, 1 completion, 2 message
   task automatic waitFor(input int w);
      for (n = 0; n < 80; n++) begin
         if ((w == 0 && (pciCmdValid || cfgLocalValid)) || (w == 1 && cplValid)
            || (w == 2 && msgValid)) return;
         idle(1);
      end
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
   endtask
   task automatic countPme;
      cnt = 0;
      repeat (60) begin
         idle(1);
         if (msgValid === 1'b1 && msgKind === MSG_PME) cnt++;
      end
   endtask
   initial begin
      idle(3);
      srst = 1'b0;
      idle(1);
      check({lockOeN, lockOutN, reqOutN}, 3'h7);
      idle(4);
      foreach (rows[i]) begin
         reqBus = rows[i].b;
         reqDev = rows[i].d;
         reqFunc = rows[i].f;
         reqReg = rows[i].r;
         send(rows[i].k, rows[i].ea);
         waitFor(0);
         check(cfgLocalValid, rows[i].loc);
         if (!rows[i].loc) begin
            check(pciCmdKind, rows[i].ek);
            check(pciCmdAddr, rows[i].ea);
         end
         idle(12);
         $display("row %0d done", i);
      end
      // locked read with lock pins disabled
      send(REQ_MEMRDLK, 32'h0000b000);
      waitFor(1);
      check({cplLocked, lockOeN}, 2'h3);
      idle(6);
      // lock held elsewhere at grant, then freed
      lockEnable = 1'b1;
      holdLock = 1'b1;
      send(REQ_MEMRDLK, 32'h0000b000);
      idle(12);
      check({reqOutN, pciCmdValid}, 2'h2);
      holdLock = 1'b0;
      waitFor(1);
      check({cplLocked, cplStatus}, {1'b1, CPL_SC});
      check({lockOeN, lockOutN}, 2'h0);
      idle(4);
      send(REQ_MEMRD, 32'h0000c000);
      waitFor(1);
      check({pciCmdValid, cplStatus}, {1'b0, CPL_UR});
      idle(4);
      send(REQ_MEMWR, 32'h0000d000);
      waitFor(0);
      idle(1);
      check(pciCmdLocked, 1'b1);
      idle(12);
      send(REQ_UNLOCK, 32'h0);
      idle(6);
      check(lockOeN, 1'b1);
      lockEnable = 1'b0;
      $display("lock test done");
      pmeInN = 1'b0;
      waitFor(2);
      check({msgKind, msgReqId, msgTag}, {MSG_PME, 16'h0500, 8'h00});
      countPme();
      check(cnt >= 2, 1'b1);
      pmeInN = 1'b1;
      idle(10);
      countPme();
      check(cnt, 0);
      $display("pme test done");
      for (int i = 0; i < 4; i++) begin
         intInN[i] = 1'b0;
         waitFor(2);
         check({msgKind, msgIntx}, {MSG_ASSERT_INTX, i[1:0]});
         idle(2);
         intInN[i] = 1'b1;
         waitFor(2);
         check({msgKind, msgIntx}, {MSG_DEASSERT_INTX, i[1:0]});
         idle(2);
      end
      $display("intx test done");
      report_and_stop();
   end
endmodule // tb_pcie_to_pci_config_lock_translator
bind pcl_xlat_top pcl_xlat_chk chk (.*);
`default_nettype wire
